// File: wdt_pkg.sv
// Purpose: Constants, register map and state type of the watchdog.
// Assumes: Byte-wide register port, one 125 MHz clock.
// Notes: Every register and timebase constant lives here; the prescaler end PRESC_LAST is derived in wdt_top.
package wdt_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_UNITS = 8'h52;
    localparam logic [7:0] ADDR_VALUE = 8'h53;
    localparam logic [7:0] ADDR_CFG = 8'h54;
    localparam logic [7:0] ADDR_CTRL = 8'h55;

    // Field positions
    localparam int UNITS_SEC_BIT = 7;
    localparam int CFG_JOY_BIT = 0;
    localparam int CFG_KBD_BIT = 1;
    localparam int CFG_MOUSE_BIT = 2;
    localparam int CFG_ROUTE_LSB = 4;
    localparam int CTRL_STATUS_BIT = 0;
    localparam int CTRL_FORCE_BIT = 2;
    localparam int CTRL_KBC_EN_BIT = 3;

    // Reset values and codes
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] CFG_WR_MASK = 8'hF7;
    localparam logic [3:0] ROUTE_OFF = 4'h0;
    localparam logic [3:0] ROUTE_INVALID = 4'h2;
    localparam int IRQ_LINES = 16;

    // Timebase
    localparam int CLK_PERIOD_NS = 8;
    localparam int SECOND_NS = 1_000_000_000;
    localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int PRESC_W = 27;
    localparam logic [5:0] SECS_PER_MIN = 6'h3C;

    // Whole state of the watchdog
    typedef struct packed {
        logic units_sec;
        logic [7:0] value;
        logic [7:0] cfg;
        logic kbc_en;
        logic status;
        logic [7:0] cnt;
        logic [PRESC_W-1:0] presc;
        logic [5:0] secs;
        logic kbd_meta;
        logic kbd_sync;
        logic kbd_prev;
        logic mouse_meta;
        logic mouse_sync;
        logic mouse_prev;
        logic kbc_meta;
        logic kbc_sync;
        logic kbc_prev;
        logic [7:0] rdata;
        logic [IRQ_LINES-1:0] irq;
    } wdt_state_s;

endpackage

// File: wdt_top.sv
// Purpose: Watchdog timer with selectable restart sources and IRQ route.
// Assumes: Register strobes and port 201h strobe are on clk_sys_in;
//          keyboard, mouse and kbc lines are asynchronous pins.
// Notes: Read data stands only in the cycle after the read strobe.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps

module wdt_top #(
    parameter int TICK_CYCLES = wdt_pkg::SEC_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic standby_rst_in,
    input wire logic bus_rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic joy_port_access_in,
    input wire logic kbd_irq_in,
    input wire logic mouse_irq_in,
    input wire logic kbc_forcing_output_line_in,
    output logic timeout_status_out,
    output logic [15:0] irq_out
);

    // Registered state and its next value
    wdt_pkg::wdt_state_s s;
    wdt_pkg::wdt_state_s next_s;

    // Last prescaler count of one second
    localparam logic [wdt_pkg::PRESC_W-1:0] PRESC_LAST =
        wdt_pkg::PRESC_W'(TICK_CYCLES - 1);

    // Rising edge of a synchronised level
    function automatic logic rise(input logic prev, input logic cur);
        rise = cur & ~prev;
    endfunction

    // Register write decode
    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = wr_in && (addr_in == a);
    endfunction

    // Combinational helpers
    logic kbd_rise;
    logic mouse_rise;
    logic kbc_rise;
    logic restart;
    logic force_to;
    logic sec_tick;
    logic unit_tick;
    logic expire;
    logic [3:0] route;

    // Edge events taken from the second sync stage onward
    always_comb begin
        kbd_rise = rise(s.kbd_prev, s.kbd_sync);
        mouse_rise = rise(s.mouse_prev, s.mouse_sync);
        kbc_rise = rise(s.kbc_prev, s.kbc_sync);
    end

    // Restart and force requests
    always_comb begin
        restart = wr_hit(wdt_pkg::ADDR_VALUE);
        if (joy_port_access_in && s.cfg[wdt_pkg::CFG_JOY_BIT]) begin
            restart = 1'b1;
        end
        if (kbd_rise && s.cfg[wdt_pkg::CFG_KBD_BIT]) begin
            restart = 1'b1;
        end
        if (mouse_rise && s.cfg[wdt_pkg::CFG_MOUSE_BIT]) begin
            restart = 1'b1;
        end
        // Software force ORed with the kbc edge detector
        force_to = wr_hit(wdt_pkg::ADDR_CTRL)
            && wdata_in[wdt_pkg::CTRL_FORCE_BIT];
        if (s.kbc_en && kbc_rise) begin
            force_to = 1'b1;
        end
    end

    // Timebase: one second pulse, then minute or second unit
    always_comb begin
        sec_tick = (s.presc == PRESC_LAST);
        unit_tick = 1'b0;
        if (sec_tick) begin
            if (s.units_sec) begin
                unit_tick = 1'b1;
            end else if (s.secs == wdt_pkg::SECS_PER_MIN - 6'h01) begin
                unit_tick = 1'b1;
            end
        end
        // Zero value never expires by counting
        expire = unit_tick && (s.value != wdt_pkg::REG_RESET)
            && (s.cnt == 8'h01);
    end

    // Next state
    always_comb begin
        next_s = s;
        next_s.rdata = 8'h00;

        // Two-stage synchronisers and edge history
        next_s.kbd_meta = kbd_irq_in;
        next_s.kbd_sync = s.kbd_meta;
        next_s.kbd_prev = s.kbd_sync;
        next_s.mouse_meta = mouse_irq_in;
        next_s.mouse_sync = s.mouse_meta;
        next_s.mouse_prev = s.mouse_sync;
        next_s.kbc_meta = kbc_forcing_output_line_in;
        next_s.kbc_sync = s.kbc_meta;
        next_s.kbc_prev = s.kbc_sync;

        // Register writes
        if (wr_hit(wdt_pkg::ADDR_UNITS)) begin
            next_s.units_sec = wdata_in[wdt_pkg::UNITS_SEC_BIT];
        end
        if (wr_hit(wdt_pkg::ADDR_VALUE)) begin
            next_s.value = wdata_in;
        end
        if (wr_hit(wdt_pkg::ADDR_CFG)) begin
            next_s.cfg = wdata_in & wdt_pkg::CFG_WR_MASK;
        end
        if (wr_hit(wdt_pkg::ADDR_CTRL)) begin
            next_s.kbc_en = wdata_in[wdt_pkg::CTRL_KBC_EN_BIT];
            next_s.status = wdata_in[wdt_pkg::CTRL_STATUS_BIT];
        end

        // Down counter: reload, count, expire
        if (restart) begin
            // Reload uses the value being written, if any
            next_s.cnt = wr_hit(wdt_pkg::ADDR_VALUE) ?
                wdata_in : s.value;
            next_s.presc = '0;
            next_s.secs = 6'h00;
        end else if (s.value != wdt_pkg::REG_RESET
                && s.cnt != 8'h00) begin
            // Counting only while enabled and not yet expired
            next_s.presc = sec_tick ? '0 : s.presc + 1'b1;
            if (sec_tick) begin
                next_s.secs = unit_tick ? 6'h00 : s.secs + 6'h01;
            end
            if (unit_tick) begin
                next_s.cnt = s.cnt - 8'h01;
            end
        end

        // Timeout sets status; set wins over a software clear
        if (expire || force_to) begin
            next_s.status = 1'b1;
        end
        if (force_to && !restart) begin
            next_s.cnt = 8'h00;
            next_s.presc = '0;
            next_s.secs = 6'h00;
        end

        // Read data, one cycle after the strobe
        if (rd_in) begin
            unique case (addr_in)
                wdt_pkg::ADDR_UNITS: begin
                    // Reserved bits read zero
                    next_s.rdata = {s.units_sec, 7'h00};
                end
                wdt_pkg::ADDR_VALUE: begin
                    next_s.rdata = s.value;
                end
                wdt_pkg::ADDR_CFG: begin
                    next_s.rdata = s.cfg;
                end
                wdt_pkg::ADDR_CTRL: begin
                    // Force bit is write-only and reads zero
                    next_s.rdata = {4'h0, s.kbc_en, 2'b00,
                        s.status};
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end

        // Interrupt route: one line, never the disable or invalid code
        route = next_s.cfg[wdt_pkg::CFG_ROUTE_LSB +: 4];
        for (int i = 0; i < wdt_pkg::IRQ_LINES; i++) begin
            next_s.irq[i] = next_s.status
                && (route == 4'(i))
                && (4'(i) != wdt_pkg::ROUTE_OFF)
                && (4'(i) != wdt_pkg::ROUTE_INVALID);
        end

        // Main and standby resets clear all; bus reset keeps status
        if (rst_in || standby_rst_in) begin
            next_s = '0;
        end else if (bus_rst_in) begin
            next_s = '0;
            next_s.status = s.status;
        end
    end

    // State register
    always_ff @(posedge clk_sys_in) begin
        s <= next_s;
    end

    // Outputs straight from flip-flops
    assign rdata_out = s.rdata;
    assign timeout_status_out = s.status;
    assign irq_out = s.irq;

endmodule // wdt_top

// File: wdt_chk.sv
// Purpose: Port checker for the watchdog top
// Assumes: Bound to every wdt_top instance
// Notes: Force check skips bus reset cycles
`timescale 1ns/1ps
module wdt_chk (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic standby_rst_in,
    input wire logic bus_rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic timeout_status_out,
    input wire logic [15:0] irq_out
);
    // Shared clock and power resets
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in || standby_rst_in);
    // Software force request
    sequence force_wr;
        wr_in && addr_in == 8'h55 && wdata_in[2] && !bus_rst_in;
    endsequence
    // Read cycle of one address
    sequence rd_of(logic [7:0] a);
        rd_in && addr_in == a;
    endsequence
    rd_slot_a: assert property (rdata_out != 8'h00 |-> $past(rd_in))
        else $error("read data outside its slot");
    force_a: assert property (force_wr |-> ##[1:2] timeout_status_out)
        else $error("force did not time out");
    status_hold_a: assert property (timeout_status_out &&
        !(wr_in && addr_in == 8'h55) |=> timeout_status_out)
        else $error("status dropped without a write");
    irq_status_a: assert property (irq_out != 16'h0000 |->
        timeout_status_out)
        else $error("irq without timeout");
    irq_bad_a: assert property (!irq_out[0] && !irq_out[2] &&
        $onehot0(irq_out))
        else $error("irq on an illegal line");
    units_rsv_a: assert property (rd_of(8'h52) |=> rdata_out[6:0] == 7'h00)
        else $error("units reserved bits set");
    cfg_rsv_a: assert property (rd_of(8'h54) |=> !rdata_out[3])
        else $error("config bit 3 set");
    force_rd_a: assert property (rd_of(8'h55) |=> !rdata_out[2])
        else $error("force bit reads one");
endmodule // wdt_chk

bind wdt_top wdt_chk u_wdt_chk (.clk_sys_in, .rst_in, .standby_rst_in,
    .bus_rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .timeout_status_out, .irq_out);

// File: tb_top.sv
// Purpose: Self-checking bench for the watchdog top
// Assumes: TICK_CYCLES of 2, so one second is 2 clocks
// Notes: Expiry windows allow for bus task overhead
`timescale 1ns/1ps
module tb_top;
    logic clk_sys_in = 0, rst_in = 1, standby_rst_in = 0, bus_rst_in = 0;
    logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
    logic wr_in = 0, rd_in = 0, joy = 0, kbd = 0, mouse = 0, kbc = 0;
    logic timeout_status_out;
    logic [15:0] irq_out;
    logic [3:0] rt [4] = '{4'h1, 4'h3, 4'hF, 4'h2};
    int fails = 0, num_checks = 0, n = 0;

    wdt_top #(.TICK_CYCLES(2)) u_wdt_top (.clk_sys_in, .rst_in,
        .standby_rst_in, .bus_rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .joy_port_access_in(joy), .kbd_irq_in(kbd),
        .mouse_irq_in(mouse), .kbc_forcing_output_line_in(kbc),
        .timeout_status_out, .irq_out);

    // Free running 125 MHz clock
    initial forever #4 clk_sys_in = ~clk_sys_in;

    task automatic report_and_stop;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One register access, returns just after the answer edge
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= w;
        rd_in <= !w;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk({8'h00, rdata_out}, {8'h00, e});
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge clk_sys_in);
        #1;
    endtask
    // Bounded wait for the timeout status
    task automatic wait_st(input int lim);
        n = 0;
        while (timeout_status_out !== 1'b1 && n < lim) begin
            idle(1);
            n++;
        end
        if (timeout_status_out !== 1'b1) begin
            chk(1'b0, 1'b1);
            report_and_stop();
        end
    endtask
    // One event from restart source s
    task automatic kick(input int s);
        @(posedge clk_sys_in);
        joy <= s == 0;
        kbd <= s == 1;
        mouse <= s == 2;
        @(posedge clk_sys_in);
        joy <= 1'b0;
        idle(2);
        kbd <= 1'b0;
        mouse <= 1'b0;
        idle(2);
    endtask
    task automatic src(input int s);
        bus(1'b1, 8'h55, 8'h00);
        bus(1'b1, 8'h54, 8'h30 | (8'h01 << s));
        bus(1'b1, 8'h53, 8'h05);
        repeat (8) kick(s);
        chk(timeout_status_out, 1'b0);
        bus(1'b1, 8'h54, 8'h30);
        repeat (4) kick(s);
        chk(timeout_status_out, 1'b1);
    endtask

    // Main sequence
    initial begin
        idle(6);
        rst_in <= 1'b0;
        rd(8'h52, 8'h00);
        rd(8'h53, 8'h00);
        bus(1'b1, 8'h60, 8'hFF);
        rd(8'h60, 8'h00);
        bus(1'b1, 8'h52, 8'hFF);
        rd(8'h52, 8'h80);
        foreach (rt[i]) begin
            bus(1'b1, 8'h54, {rt[i], 4'h0});
            bus(1'b1, 8'h55, 8'h04);
            rd(8'h55, 8'h01);
            chk(irq_out, rt[i] == 4'h2 ? 16'h0000 : 16'h0001 << rt[i]);
            bus(1'b1, 8'h55, 8'h00);
            rd(8'h55, 8'h00);
        end
        bus(1'b1, 8'h54, 8'h30);
        bus(1'b1, 8'h53, 8'h03);
        wait_st(20);
        chk(n >= 5 && n <= 7, 1'b1);
        chk(irq_out, 16'h0008);
        bus(1'b1, 8'h55, 8'h00);
        bus(1'b1, 8'h53, 8'h00);
        idle(300);
        chk(timeout_status_out, 1'b0);
        bus(1'b1, 8'h52, 8'h00);
        bus(1'b1, 8'h53, 8'h01);
        idle(100);
        wait_st(40);
        chk(n >= 18 && n <= 22, 1'b1);
        bus(1'b1, 8'h52, 8'h80);
        for (int s = 0; s < 3; s++) src(s);
        bus(1'b1, 8'h55, 8'h08);
        kbc <= 1'b1;
        wait_st(8);
        rd(8'h55, 8'h09);
        bus(1'b1, 8'h55, 8'h00);
        kbc <= 1'b0;
        idle(4);
        kbc <= 1'b1;
        idle(8);
        chk(timeout_status_out, 1'b0);
        bus(1'b1, 8'h55, 8'h04);
        bus_rst_in <= 1'b1;
        idle(1);
        bus_rst_in <= 1'b0;
        idle(1);
        chk(timeout_status_out, 1'b1);
        rd(8'h54, 8'h00);
        standby_rst_in <= 1'b1;
        idle(1);
        standby_rst_in <= 1'b0;
        idle(1);
        chk(timeout_status_out, 1'b0);
        report_and_stop();
    end
endmodule // tb_top
